// [core/pic_bank.sv]
// Register bank, interrupt persistence filter and emitter pulse train.
// Assumes the command decoder, front end and enable logic share clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module pic_bank #(
  parameter logic [3:0] DIE_REVISION = 4'h1 // Arbitrary value
)(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sf_valid_i,
  input wire logic [4:0] sf_code_i,
  input wire logic prox_irq_mask_i,
  input wire logic low_drive_range_i,
  input wire logic prox_cycle_start_i,
  input wire logic prox_done_i,
  input wire logic [15:0] prox_result_i,
  output logic prox_irq_flag_o,
  output logic irq_o,
  output logic [3:0] persistence_count_o,
  output logic wait_long_select_o,
  output logic [3:0] wait_scale_o,
  output logic [1:0] emitter_drive_level_o,
  output logic low_drive_range_o,
  output logic [1:0] diode_select_o,
  output logic [1:0] prox_gain_select_o,
  output logic emitter_pulse_o,
  output logic pulse_busy_o
);
  typedef struct packed {
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic [3:0] pers;
    logic wait_long_select;
    logic [3:0] wscale;
    logic [7:0] pulses;
    logic [1:0] drive;
    logic lowrng;
    logic [1:0] diode;
    logic [1:0] gain;
    logic [3:0] run_cnt;
    logic flag;
    logic irq;
    logic [7:0] rdata;
    pic_pkg::pic_pulse_type st;
    logic [7:0] left;
    logic [8:0] tmr;
    logic led;
    logic busy;
  } pic_state_type;

  pic_state_type q;
  pic_state_type next_q;
  logic out_range;
  logic clear_req;
  logic [3:0] run_inc;

  // Window test and clear decode
  assign out_range = (prox_result_i < q.low_thr) ||
                     (prox_result_i > q.high_thr);
  assign clear_req = sf_valid_i &&
                     (sf_code_i == pic_pkg::SF_PROX_CLEAR);
  assign run_inc = (q.run_cnt == 4'hf) ? q.run_cnt : q.run_cnt + 4'h1;

  // Next state of the whole bank
  always_comb
  begin
    next_q = q;
    // Register writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        pic_pkg::ADDR_LOW_LO: next_q.low_thr[7:0] = reg_wdata_i;
        pic_pkg::ADDR_LOW_HI: next_q.low_thr[15:8] = reg_wdata_i;
        pic_pkg::ADDR_HIGH_LO: next_q.high_thr[7:0] = reg_wdata_i;
        pic_pkg::ADDR_HIGH_HI: next_q.high_thr[15:8] = reg_wdata_i;
        pic_pkg::ADDR_PERS:
          next_q.pers = reg_wdata_i[pic_pkg::PERS_LSB +: 4];
        pic_pkg::ADDR_WAIT_CFG:
          next_q.wait_long_select = reg_wdata_i[pic_pkg::WAIT_LONG_BIT];
        pic_pkg::ADDR_PULSE: next_q.pulses = reg_wdata_i;
        pic_pkg::ADDR_CONTROL:
        begin
          next_q.drive = reg_wdata_i[7:6];
          next_q.diode = reg_wdata_i[5:4];
          next_q.gain = reg_wdata_i[3:2];
        end
        default: ;
      endcase
    end
    next_q.wscale = next_q.wait_long_select ? pic_pkg::WAIT_SCALE_LONG :
                    pic_pkg::WAIT_SCALE_SHORT;
    next_q.lowrng = low_drive_range_i;
    // Interrupt clear, then a same-cycle event wins
    if (clear_req)
    begin
      next_q.flag = 1'b0;
      next_q.run_cnt = 4'h0;
    end
    if (prox_done_i)
    begin
      if (q.pers == 4'h0)
        next_q.flag = 1'b1;
      else if (out_range)
      begin
        next_q.run_cnt = run_inc;
        if (run_inc >= q.pers)
          next_q.flag = 1'b1;
      end
      else
        next_q.run_cnt = 4'h0;
    end
    next_q.irq = next_q.flag && prox_irq_mask_i;
    // Read data, reserved bits zero
    case (reg_addr_i)
      pic_pkg::ADDR_LOW_LO: next_q.rdata = next_q.low_thr[7:0];
      pic_pkg::ADDR_LOW_HI: next_q.rdata = next_q.low_thr[15:8];
      pic_pkg::ADDR_HIGH_LO: next_q.rdata = next_q.high_thr[7:0];
      pic_pkg::ADDR_HIGH_HI: next_q.rdata = next_q.high_thr[15:8];
      pic_pkg::ADDR_PERS: next_q.rdata = {next_q.pers, 4'h0};
      pic_pkg::ADDR_WAIT_CFG: next_q.rdata = {6'h00, next_q.wait_long_select, 1'b0};
      pic_pkg::ADDR_PULSE: next_q.rdata = next_q.pulses;
      pic_pkg::ADDR_CONTROL:
        next_q.rdata = {next_q.drive, next_q.diode, next_q.gain, 2'b00};
      pic_pkg::ADDR_REVISION: next_q.rdata = {4'h0, DIE_REVISION};
      default: next_q.rdata = 8'h00;
    endcase
    // Emitter pulse train
    case (q.st)
      pic_pkg::PIC_IDLE:
        if (prox_cycle_start_i && (q.pulses != 8'h00))
        begin
          next_q.st = pic_pkg::PIC_HIGH;
          next_q.left = q.pulses;
          next_q.tmr = 9'h000;
        end
      pic_pkg::PIC_HIGH:
      begin
        next_q.tmr = q.tmr + 9'h001;
        if (q.tmr == pic_pkg::HIGH_LAST)
          next_q.st = pic_pkg::PIC_LOW;
      end
      pic_pkg::PIC_LOW:
        if (q.tmr == pic_pkg::PERIOD_LAST)
        begin
          next_q.tmr = 9'h000;
          next_q.left = q.left - 8'h01;
          next_q.st = (q.left == 8'h01) ? pic_pkg::PIC_IDLE :
                      pic_pkg::PIC_HIGH;
        end
        else
          next_q.tmr = q.tmr + 9'h001;
      default: next_q.st = pic_pkg::PIC_IDLE;
    endcase
    next_q.led = (next_q.st == pic_pkg::PIC_HIGH);
    // Busy kept in its own flop so the output is registered
    next_q.busy = (next_q.st != pic_pkg::PIC_IDLE);
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
      q.low_thr <= pic_pkg::THRESH_RESET;
      q.high_thr <= pic_pkg::THRESH_RESET;
      q.pulses <= pic_pkg::BYTE_RESET;
      q.wscale <= pic_pkg::WAIT_SCALE_SHORT;
      q.st <= pic_pkg::PIC_IDLE;
    end
    else
      q <= next_q;
  end

  // Outputs straight from the state register
  assign reg_rdata_o = q.rdata;
  assign prox_irq_flag_o = q.flag;
  assign irq_o = q.irq;
  assign persistence_count_o = q.pers;
  assign wait_long_select_o = q.wait_long_select;
  assign wait_scale_o = q.wscale;
  assign emitter_drive_level_o = q.drive;
  assign low_drive_range_o = q.lowrng;
  assign diode_select_o = q.diode;
  assign prox_gain_select_o = q.gain;
  assign emitter_pulse_o = q.led;
  assign pulse_busy_o = q.busy;

  // Checks on the bank
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence led_rise_s;
    $rose(q.led) && (q.left > 8'h01);
  endsequence
  sequence next_rise_s;
    ##[320:320] $rose(q.led);
  endsequence
  sequence high_width_s;
    ##160 $fell(q.led);
  endsequence

  out_range_hit_a: assert property (
    prox_done_i && out_range && q.pers == 4'h1 |=> q.flag)
    else $error("Out of range result did not flag");
  every_cycle_a: assert property (
    prox_done_i && q.pers == 4'h0 |=> q.flag && prox_irq_flag_o)
    else $error("Zero persistence did not flag");
  persist_hold_a: assert property (
    prox_done_i && out_range && !clear_req && q.pers != 4'h0 &&
    run_inc < q.pers && !q.flag |=> !q.flag)
    else $error("Flag raised before persistence reached");
  inside_reset_a: assert property (
    prox_done_i && !out_range && q.pers != 4'h0 |=> q.run_cnt == 4'h0)
    else $error("In-window result kept run count");
  clear_flag_a: assert property (
    clear_req && !prox_done_i |=> !q.flag ##1 !q.flag || $rose(q.flag))
    else $error("Interrupt clear ignored");
  mask_gate_a: assert property (
    irq_o |-> prox_irq_flag_o && $past(prox_irq_mask_i))
    else $error("Interrupt passed while masked");
  pers_low_zero_a: assert property (
    reg_addr_i == pic_pkg::ADDR_PERS |=> reg_rdata_o[3:0] == 4'h0)
    else $error("Reserved persistence bits not zero");
  rev_read_a: assert property (
    reg_addr_i == pic_pkg::ADDR_REVISION |=>
    reg_rdata_o == {4'h0, DIE_REVISION})
    else $error("Revision read wrong");
  wait_scale_a: assert property (
    wait_long_select_o |-> wait_scale_o == pic_pkg::WAIT_SCALE_LONG)
    else $error("Wait scale not twelve");
  thresh_pair_a: assert property (
    reg_wr_i && reg_addr_i == pic_pkg::ADDR_HIGH_HI |=>
    q.high_thr[15:8] == $past(reg_wdata_i))
    else $error("High threshold upper byte not stored");
  gain_field_a: assert property (
    reg_wr_i && reg_addr_i == pic_pkg::ADDR_CONTROL |=>
    prox_gain_select_o == $past(reg_wdata_i[3:2]) &&
    reg_rdata_o[1:0] == 2'b00)
    else $error("Gain field wrong");
  pulse_period_a: assert property (
    led_rise_s |-> next_rise_s)
    else $error("Pulse spacing wrong");

  // Pulse train, pending flag and field checks
  pulse_width_a: assert property (
    $rose(q.led) |-> high_width_s)
    else $error("Pulse high time wrong");
  burst_start_a: assert property (
    prox_cycle_start_i && !pulse_busy_o && q.pulses != 8'h00 |=>
    emitter_pulse_o && pulse_busy_o)
    else $error("Burst did not start");
  zero_count_a: assert property (
    prox_cycle_start_i && !pulse_busy_o && q.pulses == 8'h00 |=>
    !pulse_busy_o && !emitter_pulse_o)
    else $error("Burst started with zero count");
  start_refused_a: assert property (
    prox_cycle_start_i && q.st == pic_pkg::PIC_HIGH |=>
    q.left == $past(q.left))
    else $error("Start accepted while busy");
  flag_hold_a: assert property (
    prox_irq_flag_o && !clear_req |=> prox_irq_flag_o)
    else $error("Pending flag dropped without clear");
  irq_follow_a: assert property (
    prox_irq_flag_o && prox_irq_mask_i && !clear_req |=> irq_o)
    else $error("Enabled interrupt not raised");
  clear_count_a: assert property (
    clear_req && !prox_done_i |=> q.run_cnt == 4'h0)
    else $error("Interrupt clear kept run count");
  low_pair_a: assert property (
    reg_wr_i && reg_addr_i == pic_pkg::ADDR_LOW_LO |=>
    q.low_thr[7:0] == $past(reg_wdata_i))
    else $error("Low threshold lower byte not stored");
  drive_field_a: assert property (
    reg_wr_i && reg_addr_i == pic_pkg::ADDR_CONTROL |=>
    emitter_drive_level_o == $past(reg_wdata_i[7:6]))
    else $error("Drive field wrong");
  diode_field_a: assert property (
    reg_wr_i && reg_addr_i == pic_pkg::ADDR_CONTROL |=>
    diode_select_o == $past(reg_wdata_i[5:4]))
    else $error("Diode field wrong");
  low_range_a: assert property (
    low_drive_range_i |=> low_drive_range_o)
    else $error("Low drive option not passed on");
  low_range_off_a: assert property (
    !low_drive_range_i |=> !low_drive_range_o)
    else $error("Low drive option stuck");
  wait_short_a: assert property (
    !wait_long_select_o |-> wait_scale_o == pic_pkg::WAIT_SCALE_SHORT)
    else $error("Wait scale not one");
  cfg_reserved_a: assert property (
    reg_addr_i == pic_pkg::ADDR_WAIT_CFG |=>
    reg_rdata_o[7:2] == 6'h00 && reg_rdata_o[0] == 1'b0)
    else $error("Reserved configuration bits not zero");
endmodule
`default_nettype wire

// [core/pic_pkg.sv]
// Constants for the proximity interrupt configuration bank.
// Assumes a 20 MHz system clock and a byte-wide register port.
package pic_pkg;
  // Register offsets
  localparam logic [4:0] ADDR_LOW_LO = 5'h08;
  localparam logic [4:0] ADDR_LOW_HI = 5'h09;
  localparam logic [4:0] ADDR_HIGH_LO = 5'h0a;
  localparam logic [4:0] ADDR_HIGH_HI = 5'h0b;
  localparam logic [4:0] ADDR_PERS = 5'h0c;
  localparam logic [4:0] ADDR_WAIT_CFG = 5'h0d;
  localparam logic [4:0] ADDR_PULSE = 5'h0e;
  localparam logic [4:0] ADDR_CONTROL = 5'h0f;
  localparam logic [4:0] ADDR_REVISION = 5'h11;
  // Field positions
  localparam int PERS_LSB = 4;
  localparam int WAIT_LONG_BIT = 1;
  localparam int CTRL_LSB = 2;
  // Special function code for interrupt clear
  localparam logic [4:0] SF_PROX_CLEAR = 5'h05;
  // Values after reset
  localparam logic [15:0] THRESH_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Wait scale factors
  localparam logic [3:0] WAIT_SCALE_SHORT = 4'h1;
  localparam logic [3:0] WAIT_SCALE_LONG = 4'hc;
  // Pulse timing: rate in Hz, clock in Hz, derived cycle counts
  localparam int CLK_HZ = 20000000;
  localparam int PULSE_RATE_HZ = 62500;
  localparam int PULSE_PERIOD_CYC = CLK_HZ / PULSE_RATE_HZ;
  localparam int PULSE_HIGH_CYC = PULSE_PERIOD_CYC / 2;
  localparam logic [8:0] PERIOD_LAST = 9'(PULSE_PERIOD_CYC - 1);
  localparam logic [8:0] HIGH_LAST = 9'(PULSE_HIGH_CYC - 1);
  // Pulse train states, Gray along idle, high, low
  typedef enum logic [1:0]
  {
    PIC_IDLE = 2'b00,
    PIC_HIGH = 2'b01,
    PIC_LOW = 2'b11
  } pic_pulse_type;
endpackage

// [verification/pic_fe_model.sv]
// Front-end model: returns one finished proximity result per request.
// Assumes requests come at least five cycles apart on clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module pic_fe_model (
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic [15:0] value_i,
  output logic done_o,
  output logic [15:0] result_o
);
  logic [1:0] dly = 2'h0;
  initial done_o = 1'b0;
  initial result_o = 16'h0000;
  // Fixed conversion delay; result bus scrambles once its pulse is over
  always @(posedge clk_sys_i)
  begin
    done_o <= (dly == 2'h1);
    if (go_i)
      dly <= 2'h3;
    else if (dly != 2'h0)
      dly <= dly - 2'h1;
    if (dly == 2'h1)
      result_o <= value_i;
    else if (done_o)
      result_o <= ~result_o;
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Testbench: register access, interrupt filter and emitter burst.
// Assumes pic_pkg, pic_bank and pic_fe_model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic wr_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic sfv = 1'b0;
  logic [4:0] sfc = 5'h00;
  logic mask = 1'b0;
  logic ldr = 1'b0;
  logic start = 1'b0;
  logic go = 1'b0;
  logic [15:0] val = 16'h0000;
  logic [7:0] rdata;
  logic [15:0] result;
  logic done, flag, irq, wl, ldro, pulse, busy;
  logic [3:0] pcnt, ws;
  logic [1:0] drv, dio, gain;
  int err_total = 0;
  int n_checks = 0;
  int highs, i;
  // Revision value is arbitrary
  pic_bank #(.DIE_REVISION(4'h3)) i_pic_bank (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wr_i(wr_en),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sf_valid_i(sfv),
    .sf_code_i(sfc), .prox_irq_mask_i(mask), .low_drive_range_i(ldr),
    .prox_cycle_start_i(start), .prox_done_i(done), .prox_result_i(result),
    .prox_irq_flag_o(flag), .irq_o(irq), .persistence_count_o(pcnt),
    .wait_long_select_o(wl), .wait_scale_o(ws),
    .emitter_drive_level_o(drv), .low_drive_range_o(ldro),
    .diode_select_o(dio), .prox_gain_select_o(gain),
    .emitter_pulse_o(pulse), .pulse_busy_o(busy));
  pic_fe_model i_pic_fe_model (.clk_sys_i(clk_sys_i), .go_i(go),
    .value_i(val), .done_o(done), .result_o(result));
  // 20 MHz clock
  always #25 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wr_en <= 1'b1;
    wdata <= d;
    @(posedge clk_sys_i) wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_sys_i) addr <= a;
    @(posedge clk_sys_i);
    #1 chk(rdata, e);
  endtask
  // One finished result through the front end
  task automatic ev(input logic [15:0] v);
    @(posedge clk_sys_i);
    go <= 1'b1;
    val <= v;
    @(posedge clk_sys_i) go <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic sf(input logic [4:0] c);
    @(posedge clk_sys_i);
    sfv <= 1'b1;
    sfc <= c;
    @(posedge clk_sys_i) sfv <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i) ldr <= 1'b1;
    #1 chk(ws, 4'h1);
    chk({ldro, flag, irq, busy, pulse}, 5'h00);
    rd(5'h0c, 8'h00);
    wr(5'h11, 8'hff);
    rd(5'h11, 8'h03);
    rd(5'h1f, 8'h00);
    for (i = 0; i < 4; i++)
      wr(5'(8 + i), 8'(32'h5678_1234 >> (8 * i)));
    for (i = 0; i < 4; i++)
      rd(5'(8 + i), 8'(32'h5678_1234 >> (8 * i)));
    wr(5'h0c, 8'hff);
    rd(5'h0c, 8'hf0);
    chk(pcnt, 4'hf);
    wr(5'h0d, 8'h02);
    rd(5'h0d, 8'h02);
    chk({wl, ws}, 5'h1c);
    chk(ldro, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      wr(5'h0f, {i[1:0], ~i[0], i[0], ~i[1:0], 2'b11});
      rd(5'h0f, {i[1:0], ~i[0], i[0], ~i[1:0], 2'b00});
      chk({drv, dio, gain}, {i[1:0], ~i[0], i[0], ~i[1:0]});
    end
    wr(5'h0c, 8'h00);
    ev(16'h3000);
    chk({flag, irq}, 2'b10);
    @(posedge clk_sys_i) mask <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 chk(irq, 1'b1);
    sf(5'h04);
    chk(flag, 1'b1);
    sf(5'h05);
    chk({flag, irq}, 2'b00);
    wr(5'h0c, 8'h20);
    ev(16'h1233);
    ev(16'h3000);
    ev(16'h5679);
    ev(16'h1234);
    ev(16'h5678);
    ev(16'h0000);
    chk(flag, 1'b0);
    ev(16'hffff);
    chk({flag, irq}, 2'b11);
    sf(5'h05);
    ev(16'h0000);
    chk(flag, 1'b0);
    wr(5'h0c, 8'h10);
    ev(16'h6000);
    chk({flag, irq}, 2'b11);
    wr(5'h0e, 8'h00);
    @(posedge clk_sys_i) start <= 1'b1;
    @(posedge clk_sys_i) start <= 1'b0;
    #1 chk(busy, 1'b0);
    wr(5'h0e, 8'h02);
    @(posedge clk_sys_i) start <= 1'b1;
    @(posedge clk_sys_i) start <= 1'b0;
    #1 highs = 0;
    for (i = 0; i < 700 && busy === 1'b1; i++)
    begin
      highs += pulse;
      @(posedge clk_sys_i);
      start <= (i == 100);
      #1;
    end
    chk(16'(i), 16'(4 * pic_pkg::PULSE_HIGH_CYC));
    chk(16'(highs), 16'(2 * pic_pkg::PULSE_HIGH_CYC));
    end_sim();
  end
endmodule
`default_nettype wire
